// File: core/bccr_pkg.sv
/*
  Constants for the bridge chip control register bank: offsets, field
  positions, reset values, decode tables and timing counts.
  Assumes a 100 MHz system clock; every timeout cycle count derives from CLK_PERIOD_NS.
*/
package bccr_pkg;

  // Clock period of clk_sys
  localparam int CLK_PERIOD_NS = 10;

  // Dword byte offsets in configuration space
  localparam logic [7:0] OFS_CHIP_CTRL0 = 8'h40;
  localparam logic [7:0] OFS_RSVD44 = 8'h44;

  // Field positions in the dword at 0x40
  localparam int F_PF_RM_LO = 4;
  localparam int F_PF_RL_LO = 6;
  localparam int F_PF_R_LO = 8;
  localparam int F_MALF = 11;
  localparam int F_MRBC_LO = 12;
  localparam int F_FCU = 15;
  localparam int F_RETRY_STS = 16;
  localparam int F_RETRY_LO = 17;
  localparam int F_DT_DIS = 19;
  localparam int F_DT_SHORT = 20;
  localparam int F_CRT_LO = 21;
  localparam int F_ORDER = 23;
  localparam int F_CPL_LO = 24;
  localparam int F_ISO = 26;
  localparam int F_TC_LO = 27;
  localparam int F_PWR = 30;
  localparam int F_LOCK = 31;

  // Reset value: read multiple prefetch 10, cfg retry 01, completion 01, TC 001
  localparam logic [31:0] CTRL_RST = 32'h0920_0020;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;

  // Prefetch encodings
  localparam logic [1:0] PF_FULL = 2'h2;
  localparam logic [1:0] PF_ONE_LINE = 2'h0;

  // Maximum upstream read byte counts
  localparam logic [12:0] BC_128 = 13'h0080;
  localparam logic [12:0] BC_256 = 13'h0100;
  localparam logic [12:0] BC_512 = 13'h0200;
  localparam logic [12:0] BC_1024 = 13'h0400;
  localparam logic [12:0] BC_2048 = 13'h0800;
  localparam logic [12:0] BC_4096 = 13'h1000;

  // Retry expiration limits
  localparam logic [31:0] RL_256 = 32'h0000_0100;
  localparam logic [31:0] RL_64K = 32'h0001_0000;
  localparam logic [31:0] RL_2G = 32'h8000_0000;

  // Discard timer durations in PCI clocks
  localparam logic [15:0] DT_SHORT = 16'h0040;
  localparam logic [15:0] DT_BCTL_LONG = 16'h8000;
  localparam logic [15:0] DT_BCTL_SHORT = 16'h0400;

  // Configuration retry and completion timeouts, in ns
  localparam int CRT_25US_NS = 25000;
  localparam int CRT_500US_NS = 500000;
  localparam int CRT_5MS_NS = 5000000;
  localparam int CRT_25MS_NS = 25000000;
  localparam int CPL_50US_NS = 50000;
  localparam int CPL_10MS_NS = 10000000;
  localparam int CPL_50MS_NS = 50000000;

  // Same timeouts in clk_sys cycles, rounded up
  localparam int CRT_25US_CYC = (CRT_25US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CRT_500US_CYC = (CRT_500US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CRT_5MS_CYC = (CRT_5MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CRT_25MS_CYC = (CRT_25MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CPL_50US_CYC = (CPL_50US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CPL_10MS_CYC = (CPL_10MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CPL_50MS_CYC = (CPL_50MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // PCI read command kinds
  localparam logic [1:0] CMD_MR = 2'h0;
  localparam logic [1:0] CMD_MRL = 2'h1;
  localparam logic [1:0] CMD_MRM = 2'h2;

  // Discard timer states
  typedef enum logic [1:0] {
    BCCR_DT_IDLE = 2'b00,
    BCCR_DT_RUN = 2'b01,
    BCCR_DT_EXP = 2'b10
  } bccr_dt_state_t;

endpackage

// File: core/bccr_retry_cnt.sv
/*
  Counts consecutive retries of one PCI transaction and pulses on expiry.
  Assumes retry and done strobes are one-cycle pulses from clk_sys logic.
*/
`timescale 1ns/100ps
module bccr_retry_cnt
  import bccr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic retry_pulse, // Transaction retried
  input wire logic txn_done, // Transaction completed
  input wire logic limit_en, // Zero means no limit
  input wire logic [31:0] limit, // Retries allowed
  output logic expire // One-cycle expiry pulse
);

  logic [31:0] count; // Consecutive retries so far
  logic hit; // This retry reaches the limit

  // Reaching the limit on this retry
  assign hit = retry_pulse && limit_en && (count + 32'h0000_0001 >= limit);

  // Retry count, restarted by completion or expiry
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      count <= ZERO32;
    end else if (txn_done || hit) begin
      count <= ZERO32;
    end else if (retry_pulse && count != 32'hFFFF_FFFF) begin
      count <= count + 32'h0000_0001;
    end
  end

  // Expiry pulse
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      expire <= 1'b0;
    end else begin
      expire <= hit;
    end
  end

  cnt_bound_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    limit_en && $stable(limit) && $past(count) < limit |-> count < limit)
    else $error("retry count passed its limit");

endmodule

// File: core/bccr_top.sv
/*
  Chip control register bank of a PCIe-to-PCI bridge at offset 0x40, with the
  control outputs it steers, a discard timer and a retry expiry tracker.
  Assumes config requests arrive as one-cycle strobes from clk_sys logic and
  that bridge control bits and link state are clk_sys signals as well.
*/
`timescale 1ns/100ps
module bccr_top
  import bccr_pkg::*;
#(
  parameter int CRT_500US_P = CRT_500US_CYC, // 0.5 ms config retry
  parameter int CRT_5MS_P = CRT_5MS_CYC, // 5 ms config retry
  parameter int CRT_25MS_P = CRT_25MS_CYC, // 25 ms config retry
  parameter int CPL_50US_P = CPL_50US_CYC, // 50 us completion
  parameter int CPL_10MS_P = CPL_10MS_CYC, // 10 ms completion
  parameter int CPL_50MS_P = CPL_50MS_CYC // 50 ms completion
)(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cfg_req, // Config access strobe
  input wire logic cfg_wr, // Write when high
  input wire logic cfg_from_primary, // Access came from the PCIe side
  input wire logic [7:0] cfg_addr, // Byte address
  input wire logic [3:0] cfg_be, // Byte enables
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack, // Answer strobe
  output logic cfg_crs, // Answer carries CRS status
  output logic [31:0] cfg_rdata,
  input wire logic pci_rd_req, // PCI memory read being forwarded
  input wire logic [1:0] pci_rd_cmd, // MR, MRL or MRM
  input wire logic pci_rd_prefetchable, // Address in prefetchable range
  output logic up_rd_full_prefetch, // Full prefetch read in progress
  output logic [12:0] up_rd_max_bytes, // Cap on upstream read size
  output logic malformed_check_en,
  output logic [1:0] fc_credits_per_update,
  input wire logic pci_retry, // PCI transaction got a retry
  input wire logic pci_txn_done, // PCI transaction completed
  input wire logic bctl_discard_dis, // Bridge control discard disable
  input wire logic bctl_discard_short, // Bridge control discard value
  input wire logic dt_start, // Delayed completion waiting for master
  input wire logic dt_stop, // Master collected the data
  output logic dt_expired, // Discard timer expiry pulse
  output logic [23:0] cfg_retry_cycles,
  output logic dt_in_order,
  output logic cpl_timer_en,
  output logic [23:0] cpl_timeout_cycles,
  output logic [2:0] up_traffic_class,
  input wire logic link_in_l1, // Link in L1 or L1s
  output logic clk_gate_req // Gate link, transaction and PCI clocks
);

  logic [31:0] ctrl; // Stored control bits, bit 16 unused
  logic retry_sts; // Sticky retry expiry
  logic retry_exp; // Expiry pulse
  logic locked_out; // Primary access refused
  logic hit40; // Address selects 0x40
  logic hit44; // Address selects 0x44
  logic wr40; // Accepted write to 0x40
  logic sts_clr; // Write-one clear of the sticky bit
  logic [31:0] read_word; // Read mux
  logic [31:0] retry_limit; // Decoded retry limit
  logic dt_en; // Discard timer enabled
  logic [15:0] dt_limit; // Discard duration
  logic [15:0] dt_count; // Discard elapsed clocks
  bccr_dt_state_t dt_state;
  bccr_dt_state_t next_dt_state;

  // Byte-enable merge of a write into a stored word
  function automatic logic [31:0] bccr_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Full prefetch decode of one prefetch mode field
  function automatic logic bccr_full_pf(input logic [1:0] code, input logic plain_read);
    if (plain_read) begin
      return code == PF_FULL;
    end else begin
      return code != PF_ONE_LINE;
    end
  endfunction

  // Address decode and access qualification
  assign locked_out = cfg_from_primary && ctrl[F_LOCK];
  assign hit40 = cfg_addr[7:2] == OFS_CHIP_CTRL0[7:2];
  assign hit44 = cfg_addr[7:2] == OFS_RSVD44[7:2];
  assign wr40 = cfg_req && cfg_wr && hit40 && !locked_out;
  assign sts_clr = wr40 && cfg_be[2] && cfg_wdata[F_RETRY_STS];

  // Read mux; reserved dword and unmapped addresses read zero
  always_comb begin
    read_word = ZERO32;
    if (hit40) begin
      read_word = ctrl;
      read_word[F_RETRY_STS] = retry_sts;
    end else if (hit44) begin
      read_word = ZERO32;
    end
  end

  // Control word storage
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= CTRL_RST;
    end else if (wr40) begin
      ctrl <= bccr_merge(ctrl, cfg_wdata & ~(32'h0000_0001 << F_RETRY_STS), cfg_be);
    end
  end

  // Sticky retry status, a new expiry wins over a clear
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      retry_sts <= 1'b0;
    end else if (retry_exp) begin
      retry_sts <= 1'b1;
    end else if (sts_clr) begin
      retry_sts <= 1'b0;
    end
  end

  // Config answer one cycle after the request
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_ack <= 1'b0;
      cfg_crs <= 1'b0;
      cfg_rdata <= ZERO32;
    end else begin
      cfg_ack <= cfg_req;
      cfg_crs <= cfg_req && locked_out;
      if (cfg_req && !cfg_wr && !locked_out) begin
        cfg_rdata <= read_word;
      end else begin
        cfg_rdata <= ZERO32;
      end
    end
  end

  // Retry limit decode
  always_comb begin
    case (ctrl[F_RETRY_LO +: 2])
      2'h1: retry_limit = RL_256;
      2'h2: retry_limit = RL_64K;
      2'h3: retry_limit = RL_2G;
      default: retry_limit = ZERO32;
    endcase
  end

  // Per-transaction retry counter
  bccr_retry_cnt u_retry (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .retry_pulse(pci_retry),
    .txn_done(pci_txn_done),
    .limit_en(ctrl[F_RETRY_LO +: 2] != 2'h0),
    .limit(retry_limit),
    .expire(retry_exp)
  );

  // Upstream read sizing for the current PCI read
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      up_rd_full_prefetch <= 1'b0;
      up_rd_max_bytes <= BC_512;
    end else begin
      case (pci_rd_cmd)
        CMD_MR: up_rd_full_prefetch <= pci_rd_req && pci_rd_prefetchable &&
                                       bccr_full_pf(ctrl[F_PF_R_LO +: 2], 1'b1);
        CMD_MRL: up_rd_full_prefetch <= pci_rd_req && pci_rd_prefetchable &&
                                        bccr_full_pf(ctrl[F_PF_RL_LO +: 2], 1'b0);
        CMD_MRM: up_rd_full_prefetch <= pci_rd_req && pci_rd_prefetchable &&
                                        bccr_full_pf(ctrl[F_PF_RM_LO +: 2], 1'b0);
        default: up_rd_full_prefetch <= 1'b0;
      endcase
      case (ctrl[F_MRBC_LO +: 3])
        3'h1: up_rd_max_bytes <= BC_128;
        3'h2: up_rd_max_bytes <= BC_256;
        3'h4: up_rd_max_bytes <= BC_1024;
        3'h5: up_rd_max_bytes <= BC_2048;
        3'h6: up_rd_max_bytes <= BC_4096;
        default: up_rd_max_bytes <= BC_512;
      endcase
    end
  end

  // Plain control outputs
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      malformed_check_en <= 1'b0;
      fc_credits_per_update <= 2'h2;
      dt_in_order <= 1'b0;
      up_traffic_class <= 3'h0;
      clk_gate_req <= 1'b0;
    end else begin
      malformed_check_en <= ctrl[F_MALF];
      fc_credits_per_update <= ctrl[F_FCU] ? 2'h1 : 2'h2;
      dt_in_order <= ctrl[F_ORDER];
      up_traffic_class <= ctrl[F_ISO] ? ctrl[F_TC_LO +: 3] : 3'h0;
      clk_gate_req <= ctrl[F_PWR] && link_in_l1;
    end
  end

  // Timeout selects
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_retry_cycles <= 24'(CRT_500US_P);
      cpl_timer_en <= 1'b1;
      cpl_timeout_cycles <= 24'(CPL_10MS_P);
    end else begin
      case (ctrl[F_CRT_LO +: 2])
        2'h0: cfg_retry_cycles <= 24'(CRT_25US_CYC);
        2'h1: cfg_retry_cycles <= 24'(CRT_500US_P);
        2'h2: cfg_retry_cycles <= 24'(CRT_5MS_P);
        default: cfg_retry_cycles <= 24'(CRT_25MS_P);
      endcase
      cpl_timer_en <= ctrl[F_CPL_LO +: 2] != 2'h3;
      case (ctrl[F_CPL_LO +: 2])
        2'h0: cpl_timeout_cycles <= 24'(CPL_50US_P);
        2'h1: cpl_timeout_cycles <= 24'(CPL_10MS_P);
        2'h2: cpl_timeout_cycles <= 24'(CPL_50MS_P);
        default: cpl_timeout_cycles <= 24'h000000;
      endcase
    end
  end

  // Discard timer enable and duration
  assign dt_en = !ctrl[F_DT_DIS] && !bctl_discard_dis;
  assign dt_limit = ctrl[F_DT_SHORT] ? DT_SHORT :
                    (bctl_discard_short ? DT_BCTL_SHORT : DT_BCTL_LONG);

  // Discard timer next state
  always_comb begin
    next_dt_state = dt_state;
    case (dt_state)
      BCCR_DT_IDLE: begin
        if (dt_start && dt_en) begin
          next_dt_state = BCCR_DT_RUN;
        end
      end
      BCCR_DT_RUN: begin
        if (dt_stop || !dt_en) begin
          next_dt_state = BCCR_DT_IDLE;
        end else if (dt_count == dt_limit - 16'h0001) begin
          next_dt_state = BCCR_DT_EXP;
        end
      end
      BCCR_DT_EXP: next_dt_state = BCCR_DT_IDLE;
      default: next_dt_state = BCCR_DT_IDLE;
    endcase
  end

  // Discard timer state and elapsed count
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      dt_state <= BCCR_DT_IDLE;
      dt_count <= 16'h0000;
    end else begin
      dt_state <= next_dt_state;
      if (dt_state == BCCR_DT_RUN) begin
        dt_count <= dt_count + 16'h0001;
      end else begin
        dt_count <= 16'h0000;
      end
    end
  end

  assign dt_expired = dt_state == BCCR_DT_EXP;

  malf_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr40 && cfg_be[1] |-> ##2 malformed_check_en == $past(cfg_wdata[F_MALF], 2))
    else $error("malformed check enable did not follow write");

  cap_128_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ctrl[F_MRBC_LO +: 3] == 3'h1 |=> up_rd_max_bytes == BC_128)
    else $error("read cap not 128 bytes");

  mr_prefetch_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pci_rd_req && pci_rd_cmd == CMD_MR && ctrl[F_PF_R_LO +: 2] != PF_FULL |=> !up_rd_full_prefetch)
    else $error("full prefetch without code 10");

  fc_single_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ctrl[F_FCU] |=> fc_credits_per_update == 2'h1)
    else $error("flow control granule wrong");

  sticky_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    retry_exp |=> retry_sts ##1 (retry_sts || $past(sts_clr)))
    else $error("retry status not set");

  sticky_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    retry_sts && !sts_clr |=> retry_sts)
    else $error("retry status lost without clear");

  lockout_crs_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cfg_req && locked_out |=> cfg_ack && cfg_crs && cfg_rdata == ZERO32)
    else $error("primary access not answered with CRS");

  lockout_wr_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cfg_req && cfg_wr && locked_out |=> $stable(ctrl))
    else $error("locked-out write changed control");

  tc_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !ctrl[F_ISO] |=> up_traffic_class == 3'h0)
    else $error("traffic class not TC0");

  gate_l1_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !ctrl[F_PWR] |=> !clk_gate_req)
    else $error("clock gated with power saving off");

  dt_short_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    dt_state == BCCR_DT_RUN && ctrl[F_DT_SHORT] && dt_count == 16'h003F && !dt_stop && dt_en
    |=> dt_expired)
    else $error("short discard timer missed 64 clocks");

  dt_off_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ctrl[F_DT_DIS] |=> dt_state != BCCR_DT_EXP)
    else $error("discard timer ran while disabled");

endmodule

// File: sim/bccr_pci_agent.sv
/*
  Far-side model: PCI masters issuing reads and retries, and the delayed
  completion logic that starts and stops the discard timer.
  Assumes the bench calls its tasks; every signal changes at the falling edge.
*/
`timescale 1ns/100ps
module bccr_pci_agent
  import bccr_pkg::*;
(
  input wire logic clk_sys,
  output logic pci_rd_req, // Read being forwarded
  output logic [1:0] pci_rd_cmd, // Read command kind
  output logic pci_rd_prefetchable, // Address in prefetchable range
  output logic pci_retry, // Retry pulse
  output logic pci_txn_done, // Completion pulse
  output logic dt_start, // Discard timer start
  output logic dt_stop // Discard timer stop
);
  // Quiet bus at time zero, no command
  initial begin
    pci_rd_req = 1'b0;
    pci_rd_cmd = 2'h3;
    pci_rd_prefetchable = 1'b0;
    pci_retry = 1'b0;
    pci_txn_done = 1'b0;
    dt_start = 1'b0;
    dt_stop = 1'b0;
  end

  // Retry one transaction n times back to back
  task automatic retries(input int n);
    @(negedge clk_sys);
    pci_retry = 1'b1;
    repeat (n - 1) @(negedge clk_sys);
    @(negedge clk_sys);
    pci_retry = 1'b0;
  endtask

  // Transaction finally completes
  task automatic done();
    @(negedge clk_sys);
    pci_txn_done = 1'b1;
    @(negedge clk_sys);
    pci_txn_done = 1'b0;
  endtask

  // Hold a read request as a level
  task automatic read_req(input logic [1:0] cmd, input logic pf);
    @(negedge clk_sys);
    pci_rd_req = 1'b1;
    pci_rd_cmd = cmd;
    pci_rd_prefetchable = pf;
  endtask

  // Read forwarding ends, bus back to no command
  task automatic read_end();
    @(negedge clk_sys);
    pci_rd_req = 1'b0;
    pci_rd_cmd = 2'h3;
    pci_rd_prefetchable = 1'b0;
  endtask

  // Master collects its data, timer must stop
  task automatic dt_halt();
    @(negedge clk_sys);
    dt_stop = 1'b1;
    @(negedge clk_sys);
    dt_stop = 1'b0;
  endtask

  // Delayed completion waits for its master
  task automatic dt_kick();
    @(negedge clk_sys);
    dt_start = 1'b1;
    @(negedge clk_sys);
    dt_start = 1'b0;
  endtask
endmodule

// File: sim/tb_bccr_top.sv
/*
  Self-checking bench for the chip control register bank.
  Assumes bccr_pkg and bccr_top compiled first; timers shortened by parameters.
*/
`timescale 1ns/100ps
module tb_bccr_top;
  import bccr_pkg::*;
  logic clk_sys, sys_rst, cfg_req, cfg_wr, cfg_from_primary, cfg_ack, cfg_crs;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, rd_s;
  logic pci_rd_req, pci_rd_prefetchable, up_rd_full_prefetch, malformed_check_en, pci_retry, pci_txn_done;
  logic [1:0] pci_rd_cmd, fc_credits_per_update;
  logic [12:0] up_rd_max_bytes;
  logic bctl_discard_dis, bctl_discard_short, dt_start, dt_stop, dt_expired, dt_in_order, cpl_timer_en;
  logic [23:0] cfg_retry_cycles, cpl_timeout_cycles;
  logic [2:0] up_traffic_class;
  logic link_in_l1, clk_gate_req, crs_s;
  int err_total = 0;
  int n_tests = 0;

  bccr_top #(.CRT_500US_P(100), .CRT_5MS_P(200), .CRT_25MS_P(300), .CPL_50US_P(50), .CPL_10MS_P(150),
    .CPL_50MS_P(250)) i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
    .cfg_from_primary(cfg_from_primary), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_ack(cfg_ack), .cfg_crs(cfg_crs), .cfg_rdata(cfg_rdata), .pci_rd_req(pci_rd_req),
    .pci_rd_cmd(pci_rd_cmd), .pci_rd_prefetchable(pci_rd_prefetchable), .up_rd_full_prefetch(up_rd_full_prefetch),
    .up_rd_max_bytes(up_rd_max_bytes), .malformed_check_en(malformed_check_en),
    .fc_credits_per_update(fc_credits_per_update), .pci_retry(pci_retry), .pci_txn_done(pci_txn_done),
    .bctl_discard_dis(bctl_discard_dis), .bctl_discard_short(bctl_discard_short), .dt_start(dt_start),
    .dt_stop(dt_stop), .dt_expired(dt_expired), .cfg_retry_cycles(cfg_retry_cycles), .dt_in_order(dt_in_order),
    .cpl_timer_en(cpl_timer_en), .cpl_timeout_cycles(cpl_timeout_cycles), .up_traffic_class(up_traffic_class),
    .link_in_l1(link_in_l1), .clk_gate_req(clk_gate_req));

  // Far-side traffic source
  bccr_pci_agent i_agent (.clk_sys(clk_sys), .pci_rd_req(pci_rd_req), .pci_rd_cmd(pci_rd_cmd),
    .pci_rd_prefetchable(pci_rd_prefetchable), .pci_retry(pci_retry), .pci_txn_done(pci_txn_done),
    .dt_start(dt_start), .dt_stop(dt_stop));

  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Report mismatches and count every comparison
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic finish_test();
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One config access; answer is sampled in the cycle after it is taken
  task automatic cfg(input logic wr, input logic prim, input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    cfg_req = 1'b1;
    cfg_wr = wr;
    cfg_from_primary = prim;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge clk_sys);
    cfg_req = 1'b0;
    rd_s = cfg_rdata;
    crs_s = cfg_crs;
    check("cfg_ack", {31'h0, cfg_ack}, 32'h1);
  endtask

  // Secondary write, then let decoded outputs follow
  task automatic wrc(input logic [31:0] d);
    cfg(1'b1, 1'b0, OFS_CHIP_CTRL0, d);
    @(negedge clk_sys);
  endtask

  // Reset values, reserved and unmapped reads
  task automatic t_reset();
    cfg(1'b0, 1'b0, OFS_CHIP_CTRL0, ZERO32);
    check("ctrl_rst", rd_s, CTRL_RST);
    check("max_bytes_rst", {19'h0, up_rd_max_bytes}, {19'h0, BC_512});
    check("fc_rst", {30'h0, fc_credits_per_update}, 32'h2);
    check("cfg_retry_rst", {8'h0, cfg_retry_cycles}, 32'd100);
    check("cpl_rst", {7'h0, cpl_timer_en, cpl_timeout_cycles}, {7'h0, 1'b1, 24'd150});
    check("tc_rst", {29'h0, up_traffic_class}, 32'h0);
    cfg(1'b0, 1'b0, OFS_RSVD44, ZERO32);
    check("rsvd44", rd_s, ZERO32);
    cfg(1'b0, 1'b0, 8'h80, ZERO32);
    check("unmapped", rd_s, ZERO32);
  endtask

  // Every byte count code
  task automatic t_bytes();
    logic [12:0] bc [8] = '{BC_512, BC_128, BC_256, BC_512, BC_1024, BC_2048, BC_4096, BC_512};
    for (int i = 0; i < 8; i++) begin
      wrc(CTRL_RST | (i << F_MRBC_LO));
      check("max_bytes", {19'h0, up_rd_max_bytes}, {19'h0, bc[i]});
    end
  endtask

  // Full prefetch decode per read command kind and prefetchable range
  task automatic t_read_size();
    wrc(CTRL_RST | (32'h2 << F_PF_R_LO));
    i_agent.read_req(CMD_MR, 1'b1);
    @(negedge clk_sys);
    check("full_mr", {31'h0, up_rd_full_prefetch}, 32'h1);
    i_agent.read_req(CMD_MR, 1'b0);
    @(negedge clk_sys);
    check("full_np", {31'h0, up_rd_full_prefetch}, 32'h0);
    wrc(CTRL_RST);
    i_agent.read_req(CMD_MR, 1'b1);
    @(negedge clk_sys);
    check("one_line_mr", {31'h0, up_rd_full_prefetch}, 32'h0);
    i_agent.read_req(CMD_MRL, 1'b1);
    @(negedge clk_sys);
    check("one_line_mrl", {31'h0, up_rd_full_prefetch}, 32'h0);
    i_agent.read_req(CMD_MRM, 1'b1);
    @(negedge clk_sys);
    check("full_mrm", {31'h0, up_rd_full_prefetch}, 32'h1);
    i_agent.read_end();
    @(negedge clk_sys);
    check("rd_idle", {31'h0, up_rd_full_prefetch}, 32'h0);
  endtask

  // Single-bit controls, class mapping and clock gating
  task automatic t_misc();
    link_in_l1 = 1'b1;
    wrc(CTRL_RST | 32'h4080_8800 | (32'h4 << F_TC_LO) | (32'h1 << F_ISO));
    check("malformed", {31'h0, malformed_check_en}, 32'h1);
    check("fc_one", {30'h0, fc_credits_per_update}, 32'h1);
    check("in_order", {31'h0, dt_in_order}, 32'h1);
    check("tc_iso", {29'h0, up_traffic_class}, 32'h5);
    check("gate_l1", {31'h0, clk_gate_req}, 32'h1);
    link_in_l1 = 1'b0;
    @(negedge clk_sys);
    check("gate_l0", {31'h0, clk_gate_req}, 32'h0);
    wrc(CTRL_RST | (32'h4 << F_TC_LO));
    check("tc0", {29'h0, up_traffic_class}, 32'h0);
  endtask

  // Both timer selects over all codes
  task automatic t_timers();
    logic [23:0] crt [4] = '{CRT_25US_CYC[23:0], 24'd100, 24'd200, 24'd300};
    logic [23:0] cpl [4] = '{24'd50, 24'd150, 24'd250, 24'd0};
    for (int i = 0; i < 4; i++) begin
      wrc(32'h0000_0020 | (i << F_CRT_LO) | (i << F_CPL_LO));
      check("cfg_retry", {8'h0, cfg_retry_cycles}, {8'h0, crt[i]});
      check("cpl_tmo", {7'h0, cpl_timer_en, cpl_timeout_cycles}, {7'h0, i != 3, cpl[i]});
    end
  endtask

  // Retry limit, restart on completion, sticky flag and clear
  task automatic t_retry();
    wrc(CTRL_RST | (32'h1 << F_RETRY_LO));
    i_agent.retries(255);
    i_agent.done();
    i_agent.retries(1);
    repeat (3) @(negedge clk_sys);
    cfg(1'b0, 1'b0, OFS_CHIP_CTRL0, ZERO32);
    check("no_expiry", {31'h0, rd_s[16]}, 32'h0);
    i_agent.retries(255);
    repeat (3) @(negedge clk_sys);
    cfg(1'b0, 1'b0, OFS_CHIP_CTRL0, ZERO32);
    check("expiry", {31'h0, rd_s[16]}, 32'h1);
    cfg_be = 4'h3;
    wrc(32'h0001_0000);
    cfg_be = 4'hF;
    cfg(1'b0, 1'b0, OFS_CHIP_CTRL0, ZERO32);
    check("be_merge", rd_s, ((CTRL_RST | (32'h1 << F_RETRY_LO)) & 32'hFFFF_0000) | (32'h1 << F_RETRY_STS));
    wrc(CTRL_RST | (32'h1 << F_RETRY_LO) | (32'h1 << F_RETRY_STS));
    cfg(1'b0, 1'b0, OFS_CHIP_CTRL0, ZERO32);
    check("cleared", {31'h0, rd_s[16]}, 32'h0);
    wrc(CTRL_RST);
    i_agent.retries(300);
    repeat (3) @(negedge clk_sys);
    cfg(1'b0, 1'b0, OFS_CHIP_CTRL0, ZERO32);
    check("no_limit", {31'h0, rd_s[16]}, 32'h0);
  endtask

  // Cycles from start to expiry pulse, capped
  task automatic dt_run(input string name, input int exp);
    int n;
    i_agent.dt_kick();
    n = 1;
    while (dt_expired !== 1'b1 && n < 1200) begin
      @(negedge clk_sys);
      n++;
    end
    check(name, n, exp);
  endtask

  // Discard timer durations and disables
  task automatic t_discard();
    wrc(CTRL_RST | (32'h1 << F_DT_SHORT));
    dt_run("dt_short", 65);
    bctl_discard_short = 1'b1;
    wrc(CTRL_RST);
    dt_run("dt_bctl", 1025);
    i_agent.dt_kick();
    repeat (500) @(negedge clk_sys);
    i_agent.dt_halt();
    dt_run("dt_after_stop", 1025);
    wrc(CTRL_RST | (32'h1 << F_DT_DIS));
    dt_run("dt_dis", 1200);
    bctl_discard_dis = 1'b1;
    wrc(CTRL_RST);
    dt_run("dt_bctl_dis", 1200);
  endtask

  // Primary lockout answers with CRS
  task automatic t_lock();
    wrc(CTRL_RST | (32'h1 << F_LOCK));
    cfg(1'b0, 1'b1, OFS_CHIP_CTRL0, ZERO32);
    check("crs_rd", {crs_s, rd_s[30:0]}, 32'h8000_0000);
    cfg(1'b1, 1'b1, OFS_CHIP_CTRL0, CTRL_RST);
    check("crs_wr", {31'h0, crs_s}, 32'h1);
    cfg(1'b0, 1'b0, OFS_CHIP_CTRL0, ZERO32);
    check("sec_rd", rd_s, CTRL_RST | (32'h1 << F_LOCK));
    check("sec_crs", {31'h0, crs_s}, 32'h0);
  endtask

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    {cfg_req, cfg_wr, cfg_from_primary, bctl_discard_dis, bctl_discard_short, link_in_l1} = 6'h0;
    cfg_addr = 8'h00;
    cfg_be = 4'hF;
    cfg_wdata = ZERO32;
    repeat (12) @(negedge clk_sys);
    sys_rst = 1'b0;
    t_reset();
    t_bytes();
    t_read_size();
    t_misc();
    t_timers();
    t_retry();
    t_discard();
    t_lock();
    finish_test();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    finish_test();
  end
endmodule
